// File: verilog/tmr_top.sv
`timescale 1ns/1ps
`include "tmr_params.svh"

// Contract
// - overflow flag sets when the counter wraps from modulo to zero
// - read with flag set then write zero clears; new overflow voids it
// - writing one to overflow flag does nothing; reset clears it
// - overflow enable gates overflow interrupt; reset clears enable
// - stop bit freezes counter; reset sets it
// - counter-reset bit clears counter and prescaler, self-clears, reads zero
// - stop and counter-reset written together hold counter at zero
// - clock select: codes 0-6 divide bus clock by 2^n, 7 external pin
// - high-byte read latches low byte until low byte is read
// - counter registers read-only, cleared by reset and counter-reset
// - on match with modulo, flag sets and counter loads zero next tick
// - modulo high write suppresses overflow flag until low write
// - reset sets both modulo registers to all ones
// - capture channel flag sets on selected pin edge
// - compare channel flag sets when counter equals channel value
// - channel flag clears by read-then-write-zero unless new event
// - writing one to channel flag does nothing; reset clears flags
// - channel enable gates channel interrupt; reset clears enable
// - edge bits zero: pin released, mode bit A picks preset level
// - edge codes pick capture edge, or toggle/clear/set on compare
// - channel value high write suppresses compares until low write
module tmr_top
   import tmr_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        ext_clk_pin_in,
   input  wire logic [3:0]  ch_pin_in,
   output logic [3:0]       ch_pin_out,
   output logic [3:0]       ch_pin_oe_n_out,
   output logic             ovf_irq_out,
   output logic [3:0]       ch_irq_out
);
   tmr_cnt_t    cnt_r;
   tmr_cnt_t    mod_r;
   logic        mod_inh_r;
   logic        ovf_r;
   logic        ovf_arm_r;
   logic        oie_r;
   logic        stop_r;
   tmr_clksel_t ps_r;
   tmr_byte_t   lo_buf_r;
   logic        lo_held_r;
   logic        cnt_chg_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        ovf_irq_r;

   logic        acc;
   logic        wr;
   logic        rd;
   tmr_byte_t   wd;
   logic        hit_sc;
   logic        hit_cnth;
   logic        hit_cntl;
   logic        hit_modh;
   logic        hit_modl;
   logic [3:0]  hit_csc;
   logic [3:0]  hit_cvh;
   logic [3:0]  hit_cvl;
   logic        hit_any;
   logic        trst_wr;
   logic        cnt_step;
   logic        at_mod;
   logic        ovf_ev;
   tmr_byte_t   rdata;
   logic [1:0]  ch_idx;
   tmr_byte_t   chx_sc  [`TMR_NCH];
   tmr_cnt_t    chx_val [`TMR_NCH];
   logic [3:0]  chx_irq;

   tmr_tick_if tk ();
   tmr_ch_if   chx [`TMR_NCH] ();

   ////////////////////////////////////////////////////////////////////////
   // apb slave: effects land on the first access edge, pready one later
   assign acc = psel_in & penable_in & ~pready_r;
   assign wr  = acc & pwrite_in;
   assign rd  = acc & ~pwrite_in;
   assign wd  = pwdata_in[7:0];
   assign ch_idx = paddr_in[5:4];

   always_comb begin
      hit_sc   = 1'b0;
      hit_cnth = 1'b0;
      hit_cntl = 1'b0;
      hit_modh = 1'b0;
      hit_modl = 1'b0;
      hit_csc  = 4'h0;
      hit_cvh  = 4'h0;
      hit_cvl  = 4'h0;
      if (paddr_in == `TMR_ADDR_SC) begin
         hit_sc = 1'b1;
      end else if (paddr_in == `TMR_ADDR_CNTH) begin
         hit_cnth = 1'b1;
      end else if (paddr_in == `TMR_ADDR_CNTL) begin
         hit_cntl = 1'b1;
      end else if (paddr_in == `TMR_ADDR_MODH) begin
         hit_modh = 1'b1;
      end else if (paddr_in == `TMR_ADDR_MODL) begin
         hit_modl = 1'b1;
      end else if (paddr_in[7:6] == `TMR_CH_BASE_HI) begin
         if (paddr_in[3:0] == `TMR_CH_OFS_SC) begin
            hit_csc[ch_idx] = 1'b1;
         end else if (paddr_in[3:0] == `TMR_CH_OFS_VH) begin
            hit_cvh[ch_idx] = 1'b1;
         end else if (paddr_in[3:0] == `TMR_CH_OFS_VL) begin
            hit_cvl[ch_idx] = 1'b1;
         end
      end
      hit_any = hit_sc | hit_cnth | hit_cntl | hit_modh | hit_modl
                | (|hit_csc) | (|hit_cvh) | (|hit_cvl);
   end

   always_comb begin
      rdata = 8'h00;
      if (hit_sc) begin
         // counter-reset bit always reads zero
         rdata = {ovf_r, oie_r, stop_r, 1'b0, 1'b0, ps_r};
      end else if (hit_cnth) begin
         rdata = cnt_r[15:8];
      end else if (hit_cntl) begin
         rdata = lo_held_r ? lo_buf_r : cnt_r[7:0];
      end else if (hit_modh) begin
         rdata = mod_r[15:8];
      end else if (hit_modl) begin
         rdata = mod_r[7:0];
      end else if (|hit_csc) begin
         rdata = chx_sc[ch_idx];
      end else if (|hit_cvh) begin
         rdata = chx_val[ch_idx][15:8];
      end else if (|hit_cvl) begin
         rdata = chx_val[ch_idx][7:0];
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= acc;
         pslverr_r <= acc & ~hit_any;
         if (rd) begin
            prdata_r <= {24'h00_0000, rdata};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control fields of the timer status/control register
   assign trst_wr = wr & hit_sc & wd[`TMR_SC_TRST];

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         oie_r  <= 1'b0;
         stop_r <= 1'b1;
         ps_r   <= 3'h0;
      end else if (wr && hit_sc) begin
         oie_r  <= wd[`TMR_SC_OIE];
         stop_r <= wd[`TMR_SC_STOP];
         ps_r   <= wd[`TMR_SC_PS_HI:`TMR_SC_PS_LO];
      end
   end

   assign tk.clr = trst_wr;
   assign tk.run = ~stop_r;
   assign tk.sel = ps_r;

   ////////////////////////////////////////////////////////////////////////
   // counter; a tick already in flight is dropped once stop is set
   assign cnt_step = tk.tick & ~stop_r & ~trst_wr;
   assign at_mod   = (cnt_r == mod_r);
   assign ovf_ev   = cnt_step & at_mod & ~mod_inh_r;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 16'h0000;
      end else if (trst_wr) begin
         cnt_r <= 16'h0000;
      end else if (cnt_step) begin
         cnt_r <= at_mod ? 16'h0000 : cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_chg_r <= 1'b0;
      end else begin
         cnt_chg_r <= cnt_step | trst_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // overflow flag: a new overflow disarms any clear in progress
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ovf_r     <= 1'b0;
         ovf_arm_r <= 1'b0;
      end else if (ovf_ev) begin
         ovf_r     <= 1'b1;
         ovf_arm_r <= 1'b0;
      end else if (wr && hit_sc) begin
         if (!wd[`TMR_SC_OVF] && ovf_arm_r) begin
            ovf_r <= 1'b0;
         end
         ovf_arm_r <= 1'b0;
      end else if (rd && hit_sc && ovf_r) begin
         ovf_arm_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ovf_irq_r <= 1'b0;
      end else begin
         ovf_irq_r <= ovf_r & oie_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // modulo registers; writes are not blocked while counting
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mod_r     <= `TMR_MOD_RST;
         mod_inh_r <= 1'b0;
      end else if (wr && hit_modh) begin
         mod_r[15:8] <= wd;
         mod_inh_r   <= 1'b1;
      end else if (wr && hit_modl) begin
         mod_r[7:0]  <= wd;
         mod_inh_r   <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // coherent counter read; stays latched if the low byte is never read
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lo_buf_r  <= 8'h00;
         lo_held_r <= 1'b0;
      end else if (rd && hit_cnth && !lo_held_r) begin
         lo_buf_r  <= cnt_r[7:0];
         lo_held_r <= 1'b1;
      end else if (rd && hit_cntl) begin
         lo_held_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   tmr_prescaler u_presc (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .ext_clk_in (ext_clk_pin_in),
      .tk         (tk.presc)
   );

   for (genvar i = 0; i < `TMR_NCH; i++) begin : g_ch
      assign chx[i].wr_sc   = wr & hit_csc[i];
      assign chx[i].wr_vh   = wr & hit_cvh[i];
      assign chx[i].wr_vl   = wr & hit_cvl[i];
      assign chx[i].rd_sc   = rd & hit_csc[i];
      assign chx[i].rd_vh   = rd & hit_cvh[i];
      assign chx[i].rd_vl   = rd & hit_cvl[i];
      assign chx[i].wdata   = wd;
      assign chx[i].cnt     = cnt_r;
      assign chx[i].cnt_chg = cnt_chg_r;
      assign chx_sc[i]      = chx[i].sc;
      assign chx_val[i]     = chx[i].val;
      assign chx_irq[i]     = chx[i].irq;

      tmr_channel u_ch (
         .clk_in       (clk_in),
         .rst_n_in     (rst_n_in),
         .pin_in       (ch_pin_in[i]),
         .pin_out      (ch_pin_out[i]),
         .pin_oe_n_out (ch_pin_oe_n_out[i]),
         .ch           (chx[i].chan)
      );
   end

   assign prdata_out  = prdata_r;
   assign pready_out  = pready_r;
   assign pslverr_out = pslverr_r;
   assign ovf_irq_out = ovf_irq_r;
   assign ch_irq_out  = chx_irq;
endmodule : tmr_top

// File: verilog/tmr_params.svh
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

// register byte addresses
`define TMR_ADDR_SC        8'h00
`define TMR_ADDR_CNTH      8'h04
`define TMR_ADDR_CNTL      8'h08
`define TMR_ADDR_MODH      8'h0c
`define TMR_ADDR_MODL      8'h10
// channel n block at 8'h40 + n*8'h10
`define TMR_CH_BASE_HI     2'b01
`define TMR_CH_OFS_SC      4'h0
`define TMR_CH_OFS_VH      4'h4
`define TMR_CH_OFS_VL      4'h8

// timer status/control fields
`define TMR_SC_OVF         7
`define TMR_SC_OIE         6
`define TMR_SC_STOP        5
`define TMR_SC_TRST        4
`define TMR_SC_PS_HI       2
`define TMR_SC_PS_LO       0
`define TMR_SC_RST         8'h20

// channel status/control fields
`define TMR_CH_FLAG        7
`define TMR_CH_IE          6
`define TMR_CH_MSB         5
`define TMR_CH_MSA         4
`define TMR_CH_ELSB        3
`define TMR_CH_ELSA        2

`define TMR_MOD_RST        16'hffff
`define TMR_PS_EXT         3'h7
`define TMR_NCH            4

`endif

// File: verilog/tmr_pkg.sv
package tmr_pkg;
   typedef logic [7:0]  tmr_byte_t;
   typedef logic [15:0] tmr_cnt_t;
   typedef logic [2:0]  tmr_clksel_t;
   typedef enum logic [2:0] {
      TMR_CM_PORT = 3'b001,
      TMR_CM_CAPT = 3'b010,
      TMR_CM_CMP  = 3'b100
   } tmr_chmode_t;
endpackage : tmr_pkg

// File: verilog/tmr_if.sv
`timescale 1ns/1ps

interface tmr_tick_if;
   import tmr_pkg::*;
   logic        clr;
   logic        run;
   tmr_clksel_t sel;
   logic        tick;
   modport presc (input clr, input run, input sel, output tick);
   modport core  (output clr, output run, output sel, input tick);
endinterface : tmr_tick_if

interface tmr_ch_if;
   import tmr_pkg::*;
   logic      wr_sc;
   logic      wr_vh;
   logic      wr_vl;
   logic      rd_sc;
   logic      rd_vh;
   logic      rd_vl;
   tmr_byte_t wdata;
   tmr_cnt_t  cnt;
   logic      cnt_chg;
   tmr_byte_t sc;
   tmr_cnt_t  val;
   logic      irq;
   modport chan (input wr_sc, input wr_vh, input wr_vl, input rd_sc,
                 input rd_vh, input rd_vl, input wdata, input cnt,
                 input cnt_chg, output sc, output val, output irq);
   modport core (output wr_sc, output wr_vh, output wr_vl, output rd_sc,
                 output rd_vh, output rd_vl, output wdata, output cnt,
                 output cnt_chg, input sc, input val, input irq);
endinterface : tmr_ch_if

// File: verilog/tmr_prescaler.sv
`timescale 1ns/1ps
`include "tmr_params.svh"

module tmr_prescaler
   import tmr_pkg::*;
(
   input  wire logic  clk_in,
   input  wire logic  rst_n_in,
   input  wire logic  ext_clk_in,
   tmr_tick_if.presc  tk
);
   logic [5:0] div_r;
   logic       ext_s1_r;
   logic       ext_s2_r;
   logic       ext_s3_r;
   logic       tick_r;
   logic [5:0] mask;
   logic       tick_nxt;

   ////////////////////////////////////////////////////////////////////////
   // external count clock: two-stage sync, then rising-edge detect
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_s3_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_clk_in;
         ext_s2_r <= ext_s1_r;
         ext_s3_r <= ext_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_r <= 6'h00;
      end else if (tk.clr) begin
         div_r <= 6'h00;
      end else if (tk.run) begin
         div_r <= div_r + 6'h01;
      end
   end

   always_comb begin
      mask = 6'(7'h7f >> (3'h7 - tk.sel)) & 6'h3f;
      if (tk.sel == `TMR_PS_EXT) begin
         tick_nxt = ext_s2_r & ~ext_s3_r;
      end else begin
         tick_nxt = ((div_r & mask) == mask);
      end
   end

   // tick is registered, so it trails the divider by one bus clock
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= tick_nxt & tk.run & ~tk.clr;
      end
   end

   assign tk.tick = tick_r;
endmodule : tmr_prescaler

// File: verilog/tmr_channel.sv
`timescale 1ns/1ps
`include "tmr_params.svh"

module tmr_channel
   import tmr_pkg::*;
(
   input  wire logic  clk_in,
   input  wire logic  rst_n_in,
   input  wire logic  pin_in,
   output logic       pin_out,
   output logic       pin_oe_n_out,
   tmr_ch_if.chan     ch
);
   logic        flag_r;
   logic        ie_r;
   logic        msb_r;
   logic        msa_r;
   logic [1:0]  els_r;
   tmr_cnt_t    val_r;
   logic        cmp_inh_r;
   logic        cap_inh_r;
   logic        arm_r;
   logic        irq_r;
   logic        s1_r;
   logic        s2_r;
   logic        s3_r;
   tmr_chmode_t mode;
   logic        edge_hit;
   logic        cap_ev;
   logic        cmp_ev;
   logic        ev;

   always_comb begin
      if (els_r == 2'b00) begin
         mode = TMR_CM_PORT;
      end else if (msb_r || msa_r) begin
         mode = TMR_CM_CMP;
      end else begin
         mode = TMR_CM_CAPT;
      end
      case (els_r)
         2'b01:   edge_hit = s2_r & ~s3_r;
         2'b10:   edge_hit = ~s2_r & s3_r;
         2'b11:   edge_hit = s2_r ^ s3_r;
         default: edge_hit = 1'b0;
      endcase
   end

   assign cap_ev = (mode == TMR_CM_CAPT) && edge_hit && !cap_inh_r;
   assign cmp_ev = (mode == TMR_CM_CMP) && ch.cnt_chg
                   && (ch.cnt == val_r) && !cmp_inh_r;
   assign ev     = cap_ev | cmp_ev;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // a new event beats a clearing write in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         flag_r <= 1'b0;
         arm_r  <= 1'b0;
      end else if (ev) begin
         flag_r <= 1'b1;
         arm_r  <= 1'b0;
      end else if (ch.wr_sc) begin
         if (!ch.wdata[`TMR_CH_FLAG] && arm_r) begin
            flag_r <= 1'b0;
         end
         arm_r <= 1'b0;
      end else if (ch.rd_sc && flag_r) begin
         arm_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ie_r  <= 1'b0;
         msb_r <= 1'b0;
         msa_r <= 1'b0;
         els_r <= 2'b00;
      end else if (ch.wr_sc) begin
         ie_r  <= ch.wdata[`TMR_CH_IE];
         msb_r <= ch.wdata[`TMR_CH_MSB];
         msa_r <= ch.wdata[`TMR_CH_MSA];
         els_r <= ch.wdata[`TMR_CH_ELSB:`TMR_CH_ELSA];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // value register: software writes win over a capture in the same cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         val_r     <= 16'h0000;
         cmp_inh_r <= 1'b0;
      end else if (ch.wr_vh) begin
         val_r[15:8] <= ch.wdata;
         cmp_inh_r   <= 1'b1;
      end else if (ch.wr_vl) begin
         val_r[7:0]  <= ch.wdata;
         cmp_inh_r   <= 1'b0;
      end else if (cap_ev) begin
         val_r <= ch.cnt;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cap_inh_r <= 1'b0;
      end else if (ch.rd_vh && mode == TMR_CM_CAPT) begin
         cap_inh_r <= 1'b1;
      end else if (ch.rd_vl) begin
         cap_inh_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_out      <= 1'b1;
         pin_oe_n_out <= 1'b1;
      end else begin
         pin_oe_n_out <= (mode != TMR_CM_CMP);
         if (mode == TMR_CM_PORT) begin
            pin_out <= ~msa_r;
         end else if (cmp_ev) begin
            case (els_r)
               2'b01:   pin_out <= ~pin_out;
               2'b10:   pin_out <= 1'b0;
               default: pin_out <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= flag_r & ie_r;
      end
   end

   assign ch.sc  = {flag_r, ie_r, msb_r, msa_r, els_r, 2'b00};
   assign ch.val = val_r;
   assign ch.irq = irq_r;
endmodule : tmr_channel

// File: tb/tmr_top_properties.sv
`timescale 1ns/1ps

module tmr_top_properties (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [7:0]  paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic [3:0]  ch_pin_out,
   input wire logic [3:0]  ch_pin_oe_n_out,
   input wire logic        ovf_irq_out,
   input wire logic [3:0]  ch_irq_out
);
   logic       take;
   logic [2:0] wr_hist_r;

   assign take = psel_in && penable_in && !pready_out;

   // an interrupt may only drop shortly after a register write
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_hist_r <= 3'h0;
      end else begin
         wr_hist_r <= {wr_hist_r[1:0], take && pwrite_in};
      end
   end

   function automatic logic mapped(input logic [7:0] a);
      return (a inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) ||
             (a[7:6] == 2'b01 && a[3:0] inside {4'h0, 4'h4, 4'h8});
   endfunction : mapped

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   ///////////////////////////////////////////////////////////////////////
   a_ready_after:
      assert property (take |=> pready_out)
      else $error("ready missing after access");
   a_ready_once:
      assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   a_err_decode:
      assert property (pready_out |-> pslverr_out == !mapped(paddr_in))
      else $error("error response wrong for address");
   a_rdata_hold:
      assert property (!(take && !pwrite_in) |=> $stable(prdata_out))
      else $error("read data moved without a read");
   a_rdata_upper:
      assert property (prdata_out[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_rst_quiet:
      assert property ($rose(rst_n_in) |-> !ovf_irq_out && ch_irq_out == 4'h0)
      else $error("interrupt active after reset");
   a_rst_pins:
      assert property ($rose(rst_n_in) |->
         ch_pin_oe_n_out == 4'hf && ch_pin_out == 4'hf)
      else $error("channel pins not released after reset");
   a_ovf_fall:
      assert property ($fell(ovf_irq_out) |-> |wr_hist_r)
      else $error("overflow interrupt dropped without a write");
   a_ch_fall:
      assert property ((|($past(ch_irq_out) & ~ch_irq_out)) |-> |wr_hist_r)
      else $error("channel interrupt dropped without a write");
endmodule : tmr_top_properties

bind tmr_top tmr_top_properties u_tmr_top_properties (
   .clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
   .prdata_out, .pready_out, .pslverr_out, .ch_pin_out, .ch_pin_oe_n_out,
   .ovf_irq_out, .ch_irq_out
);

// File: tb/tmr_top_tb.sv
`timescale 1ns/1ps
`include "tmr_params.svh"

module tmr_top_tb;
   logic        clk_in, rst_n_in, psel_in, penable_in, pwrite_in;
   logic        pready_out, pslverr_out, ext_clk_pin_in, ovf_irq_out;
   logic [7:0]  paddr_in, d;
   logic [31:0] pwdata_in, prdata_out, q, q1;
   logic [3:0]  ch_pin_in, ch_pin_out, ch_pin_oe_n_out, ch_irq_out;
   logic [4:0]  irqv;
   int          miscompares, check_count;

   assign irqv = {ch_irq_out, ovf_irq_out};

   tmr_top u_tmr_top (.clk_in, .rst_n_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
      .pslverr_out, .ext_clk_pin_in, .ch_pin_in, .ch_pin_out,
      .ch_pin_oe_n_out, .ovf_irq_out, .ch_irq_out);

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   ///////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask : chk

   // request held from setup until pready is seen high at an edge
   task automatic bus(input logic w, input logic [7:0] a, wd,
                      output logic [31:0] rd);
      int i;
      @(posedge clk_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= w;
      paddr_in   <= a;
      pwdata_in  <= {24'h0, wd};
      @(posedge clk_in);
      penable_in <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_in);
         if (pready_out === 1'b1) break;
      end
      rd = prdata_out;
      if (i == 20) begin
         $display("Error pready expected 1 seen %b", pready_out);
         miscompares++;
         finish_test();
      end
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, v);
      bus(1'b1, a, v, q);
   endtask : wr

   task automatic rc(input logic [7:0] a, e);
      bus(1'b0, a, 8'h00, q);
      chk($sformatf("reg %h", a), {24'h0, e}, q);
   endtask : rc

   // two live low-byte reads spaced idle+4 cycles apart
   task automatic ms(input int idle, input logic x, output logic [7:0] dl);
      bus(1'b0, `TMR_ADDR_CNTL, 8'h00, q1);
      for (int i = 0; i < idle; i++) begin
         @(posedge clk_in);
         if (x) ext_clk_pin_in <= i[2];
      end
      bus(1'b0, `TMR_ADDR_CNTL, 8'h00, q);
      dl = q[7:0] - q1[7:0];
   endtask : ms

   task automatic wt(input int b);
      for (int i = 0; i < 3000; i++) begin
         @(negedge clk_in);
         if (irqv[b] === 1'b1) return;
      end
      $display("Error irq %0d expected 1 seen 0", b);
      miscompares++;
      finish_test();
   endtask : wt

   ///////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n_in, psel_in, penable_in, pwrite_in, ext_clk_pin_in} = 5'h0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0;
      ch_pin_in = 4'h0;
      miscompares = 0;
      check_count = 0;
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rc(`TMR_ADDR_SC, `TMR_SC_RST);
      rc(`TMR_ADDR_MODH, 8'hff);
      rc(`TMR_ADDR_MODL, 8'hff);
      rc(8'h40, 8'h00);
      wr(`TMR_ADDR_CNTH, 8'h5a);
      rc(`TMR_ADDR_CNTH, 8'h00);
      rc(`TMR_ADDR_CNTL, 8'h00);
      rc(8'h24, 8'h00);
      $display("test reset done");
      for (int n = 0; n < 7; n++) begin
         wr(`TMR_ADDR_SC, n[7:0]);
         ms(124, 1'b0, d);
         chk("steps", 32'd128 >> n, {24'h0, d});
      end
      wr(`TMR_ADDR_SC, 8'h07);
      ms(44, 1'b1, d);
      chk("ext steps", 32'd5, {24'h0, d});
      wr(`TMR_ADDR_SC, 8'h20);
      ms(20, 1'b0, d);
      chk("stopped", 32'd0, {24'h0, d});
      wr(`TMR_ADDR_SC, 8'h00);
      bus(1'b0, `TMR_ADDR_CNTH, 8'h00, q);
      bus(1'b0, `TMR_ADDR_CNTH, 8'h00, q);
      ms(0, 1'b0, d);
      chk("latched low", 32'd12, {24'h0, d});
      wr(`TMR_ADDR_SC, 8'h30);
      rc(`TMR_ADDR_CNTH, 8'h00);
      rc(`TMR_ADDR_CNTL, 8'h00);
      wr(`TMR_ADDR_SC, 8'h00);
      repeat (300) @(posedge clk_in);
      wr(`TMR_ADDR_SC, 8'h10);
      rc(`TMR_ADDR_SC, 8'h00);
      rc(`TMR_ADDR_CNTH, 8'h00);
      rc(`TMR_ADDR_MODL, 8'hff);
      $display("test counter done");
      wr(`TMR_ADDR_SC, 8'h30);
      wr(`TMR_ADDR_MODH, 8'h00);
      wr(`TMR_ADDR_MODL, 8'h03);
      wr(`TMR_ADDR_SC, 8'h40);
      wt(0);
      wr(`TMR_ADDR_SC, 8'h60);
      rc(`TMR_ADDR_SC, 8'he0);
      wr(`TMR_ADDR_SC, 8'h60);
      rc(`TMR_ADDR_SC, 8'h60);
      wr(`TMR_ADDR_SC, 8'he0);
      rc(`TMR_ADDR_SC, 8'h60);
      @(negedge clk_in);
      chk("ovf irq", 32'd0, {31'h0, ovf_irq_out});
      wr(`TMR_ADDR_SC, 8'h30);
      wr(`TMR_ADDR_MODH, 8'h00);
      wr(`TMR_ADDR_SC, 8'h40);
      repeat (20) @(posedge clk_in);
      rc(`TMR_ADDR_SC, 8'h40);
      wr(`TMR_ADDR_SC, 8'h30);
      wr(`TMR_ADDR_MODL, 8'h01);
      wr(`TMR_ADDR_SC, 8'h40);
      wt(0);
      rc(`TMR_ADDR_SC, 8'hc0);
      wr(`TMR_ADDR_SC, 8'h40);
      wr(`TMR_ADDR_SC, 8'h60);
      rc(`TMR_ADDR_SC, 8'he0);
      $display("test overflow done");
      wr(`TMR_ADDR_SC, 8'h30);
      wr(`TMR_ADDR_MODH, 8'hff);
      wr(`TMR_ADDR_MODL, 8'hff);
      wr(8'h44, 8'h00);
      wr(8'h48, 8'h20);
      wr(8'h40, 8'h54);
      wr(8'h50, 8'h44);
      wr(8'h60, 8'h48);
      wr(8'h70, 8'h4c);
      wr(`TMR_ADDR_SC, 8'h00);
      wt(1);
      chk("ch0 oe_n", 32'd0, {31'h0, ch_pin_oe_n_out[0]});
      chk("ch0 pin", 32'd0, {31'h0, ch_pin_out[0]});
      rc(8'h40, 8'hd4);
      wr(8'h40, 8'h54);
      rc(8'h40, 8'h54);
      ch_pin_in <= 4'hf;
      repeat (8) @(posedge clk_in);
      rc(8'h50, 8'hc4);
      rc(8'h60, 8'h48);
      rc(8'h70, 8'hcc);
      chk("ch irq", 32'ha, {28'h0, ch_irq_out});
      ch_pin_in <= 4'h0;
      repeat (8) @(posedge clk_in);
      rc(8'h60, 8'hc8);
      wr(8'h40, 8'h00);
      repeat (4) @(negedge clk_in);
      chk("ch0 high", 32'd1, {31'h0, ch_pin_out[0]});
      chk("ch0 oe_n", 32'd1, {31'h0, ch_pin_oe_n_out[0]});
      wr(8'h40, 8'h10);
      repeat (4) @(negedge clk_in);
      chk("ch0 level", 32'd0, {31'h0, ch_pin_out[0]});
      $display("test channels done");
      finish_test();
   end
endmodule : tmr_top_tb
